//--- icr_bank.sv
// Function
// - contents undefined after reset; write before use
// - oscillator and gain coefficients are two's complement
// - receive sample multiplied by twelve-bit gain
// - transmit sample scaled by same-scale gain
// - ringing dc offset, 1.5 V per code
// - tone generators use addresses 13-15, 16-18
// - ringing uses addresses 19, 20, 21, 22
// - metering uses addresses 23, 24, 25
// - line fields sized six, eight, thirteen, four
// - loop closure threshold with optional hysteresis
// - common-mode thresholds widen line-feed bandwidth
`include "icr_defines.svh"

module icr_bank #(
   parameter int SAMPLE_W = 16
) (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rst_b,
   // register port
   input  wire logic [`ICR_ADDR_W-1:0]      reg_addr,
   input  wire logic [`ICR_DATA_W-1:0]      reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [`ICR_DATA_W-1:0]      reg_rdata,
   // coefficient sets to generators
   output icr_pkg::icr_osc_t                tone_one_coef,
   output icr_pkg::icr_osc_t                tone_two_coef,
   output icr_pkg::icr_ring_t               ring_coef,
   output logic      [`ICR_OFS_HV_W-1:0]    ring_offset_halfvolt,
   output icr_pkg::icr_meter_t              meter_coef,
   output icr_pkg::icr_line_t               line_coef,
   output icr_pkg::icr_ctrl_t               func_enable,
   output icr_pkg::icr_ready_t              coef_ready,
   // receive gain path
   input  wire logic signed [SAMPLE_W-1:0]  rx_raw,
   input  wire logic                        rx_raw_valid,
   output logic signed      [SAMPLE_W-1:0]  rx_scaled,
   output logic                             rx_scaled_valid,
   // transmit gain path
   input  wire logic signed [SAMPLE_W-1:0]  tx_raw,
   input  wire logic                        tx_raw_valid,
   output logic signed      [SAMPLE_W-1:0]  tx_scaled,
   output logic                             tx_scaled_valid,
   // line measurements and detector results
   input  wire logic        [5:0]           loop_current,
   input  wire logic signed [6:0]           cm_level,
   output logic                             loop_closed,
   output logic                             cm_speedup
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (SAMPLE_W < 8 || SAMPLE_W > 24) begin : g_bad_width
      $error("icr_bank: SAMPLE_W must lie in 8..24");
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   // address lands on a storable coefficient slot
   function automatic logic icr_is_coef(input logic [`ICR_ADDR_W-1:0] a);
      return a >= `ICR_ADDR_FIRST && a <= `ICR_ADDR_LAST && a != `ICR_ADDR_RSVD;
   endfunction

   // signed multiply by gain, drop fraction, saturate
   function automatic logic signed [SAMPLE_W-1:0] icr_scale(
      input logic signed [SAMPLE_W-1:0]      s,
      input logic signed [`ICR_GAIN_W-1:0]   g
   );
      logic signed [SAMPLE_W+`ICR_GAIN_W-1:0] prod;
      logic signed [SAMPLE_W+`ICR_GAIN_W-1:0] shf;
      prod = s * g;
      shf  = prod >>> `ICR_GAIN_FRAC;
      if (&shf[SAMPLE_W+`ICR_GAIN_W-1:SAMPLE_W-1] || ~|shf[SAMPLE_W+`ICR_GAIN_W-1:SAMPLE_W-1])
         return shf[SAMPLE_W-1:0];
      else if (shf[SAMPLE_W+`ICR_GAIN_W-1])
         return {1'b1, {(SAMPLE_W-1){1'b0}}};
      else
         return {1'b0, {(SAMPLE_W-1){1'b1}}};
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   logic [`ICR_DATA_W-1:0]   coef_mem_r [`ICR_ADDR_FIRST:`ICR_ADDR_LAST];
   logic [`ICR_ADDR_LAST:`ICR_ADDR_FIRST] written_r, written_nxt;
   icr_pkg::icr_ctrl_t       ctrl_r, ctrl_nxt;
   logic [`ICR_DATA_W-1:0]   rdata_r, rdata_nxt;
   logic [`ICR_OFS_HV_W-1:0] ofs_hv_r, ofs_hv_nxt;
   logic signed [SAMPLE_W-1:0] rx_r, rx_nxt, tx_r, tx_nxt;
   logic                     rx_v_r, rx_v_nxt, tx_v_r, tx_v_nxt;
   logic                     lc_r, lc_nxt, cm_r, cm_nxt;
   icr_pkg::icr_ready_t      ready;
   logic signed [`ICR_GAIN_W-1:0] rx_gain, tx_gain;
   logic signed [7:0]        cm_hi_s, cm_lo_s;

   // ****************************************************************
   // coefficient storage
   // ****************************************************************
   // no reset on the array: contents are undefined until written
   always_ff @(posedge sys_clk) begin
      if (reg_wr && icr_is_coef(reg_addr)) begin
         coef_mem_r[reg_addr] <= reg_wdata; // all sixteen bits kept
      end
   end

   // ****************************************************************
   // register port and written tracking
   // ****************************************************************
   // next values for bus, control and written flags
   always_comb begin
      written_nxt = written_r;
      ctrl_nxt    = ctrl_r;
      rdata_nxt   = '0;
      if (reg_wr && icr_is_coef(reg_addr)) begin
         written_nxt[reg_addr] = 1'b1;
      end
      if (reg_wr && reg_addr == `ICR_ADDR_CTRL) begin
         ctrl_nxt = reg_wdata[7:0];
      end
      if (reg_rd) begin
         if (icr_is_coef(reg_addr)) begin
            rdata_nxt = coef_mem_r[reg_addr];
         end else if (reg_addr == `ICR_ADDR_STATUS) begin
            rdata_nxt = {9'h000, ready};
         end else if (reg_addr == `ICR_ADDR_CTRL) begin
            rdata_nxt = {8'h00, ctrl_r};
         end
      end
   end

   // register bus, control and written flags
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         written_r <= '0;
         ctrl_r    <= `ICR_CTRL_RST;
         rdata_r   <= '0;
      end else begin
         written_r <= written_nxt;
         ctrl_r    <= ctrl_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // group readiness from written flags
   assign ready.tone_one = &written_r[`ICR_ADDR_TONE1_PHS:`ICR_ADDR_TONE1_FRQ];
   assign ready.tone_two = &written_r[`ICR_ADDR_TONE2_PHS:`ICR_ADDR_TONE2_FRQ];
   assign ready.ring     = &written_r[`ICR_ADDR_RING_PHS:`ICR_ADDR_RING_OFS];
   assign ready.meter    = &written_r[`ICR_ADDR_MTR_FRQ:`ICR_ADDR_MTR_RAMP];
   assign ready.rx_gain  = written_r[`ICR_ADDR_RX_GAIN];
   assign ready.tx_gain  = written_r[`ICR_ADDR_TX_GAIN];
   assign ready.line     = &written_r[`ICR_ADDR_OVERHEAD:`ICR_ADDR_LC_UPPER]
                           & written_r[`ICR_ADDR_LC_LOWER];

   // tone, ring, meter and gain functions run only once their coefficients hold defined values; hysteresis and range select pass straight through
   assign func_enable.tone_one_en = ctrl_r.tone_one_en & ready.tone_one;
   assign func_enable.tone_two_en = ctrl_r.tone_two_en & ready.tone_two;
   assign func_enable.ring_en     = ctrl_r.ring_en & ready.ring;
   assign func_enable.meter_en    = ctrl_r.meter_en & ready.meter;
   assign func_enable.rx_gain_en  = ctrl_r.rx_gain_en & ready.rx_gain;
   assign func_enable.tx_gain_en  = ctrl_r.tx_gain_en & ready.tx_gain;
   assign func_enable.lc_hyst_en  = ctrl_r.lc_hyst_en;
   assign func_enable.overhead_range_select = ctrl_r.overhead_range_select;
   assign coef_ready = ready;
   assign reg_rdata  = rdata_r;

   // ****************************************************************
   // coefficient fan-out
   // ****************************************************************
   // oscillator sets
   assign tone_one_coef = {coef_mem_r[`ICR_ADDR_TONE1_FRQ], coef_mem_r[`ICR_ADDR_TONE1_AMP],
                           coef_mem_r[`ICR_ADDR_TONE1_PHS]};
   assign tone_two_coef = {coef_mem_r[`ICR_ADDR_TONE2_FRQ], coef_mem_r[`ICR_ADDR_TONE2_AMP],
                           coef_mem_r[`ICR_ADDR_TONE2_PHS]};
   assign ring_coef     = {coef_mem_r[`ICR_ADDR_RING_OFS][`ICR_OFS_W-1:0],
                           coef_mem_r[`ICR_ADDR_RING_FRQ], coef_mem_r[`ICR_ADDR_RING_AMP],
                           coef_mem_r[`ICR_ADDR_RING_PHS]};
   assign meter_coef    = {coef_mem_r[`ICR_ADDR_MTR_RAMP], coef_mem_r[`ICR_ADDR_MTR_AMP],
                           coef_mem_r[`ICR_ADDR_MTR_FRQ]};

   // line-control fields cut to their defined widths
   assign line_coef.lc_upper  = coef_mem_r[`ICR_ADDR_LC_UPPER][`ICR_THR_W-1:0];
   assign line_coef.lc_lower  = coef_mem_r[`ICR_ADDR_LC_LOWER][`ICR_THR_W-1:0];
   assign line_coef.ring_trip = coef_mem_r[`ICR_ADDR_RT_THR][`ICR_THR_W-1:0];
   assign line_coef.cm_low    = coef_mem_r[`ICR_ADDR_CM_LOW][`ICR_THR_W-1:0];
   assign line_coef.cm_high   = coef_mem_r[`ICR_ADDR_CM_HIGH][`ICR_THR_W-1:0];
   assign line_coef.alarm_a   = coef_mem_r[`ICR_ADDR_ALARM_A][`ICR_ALARM_W-1:0];
   assign line_coef.alarm_b   = coef_mem_r[`ICR_ADDR_ALARM_B][`ICR_ALARM_W-1:0];
   assign line_coef.alarm_c   = coef_mem_r[`ICR_ADDR_ALARM_C][`ICR_ALARM_W-1:0];
   assign line_coef.lc_filter = coef_mem_r[`ICR_ADDR_LC_FILT][`ICR_FILT_W-1:0];
   assign line_coef.rt_filter = coef_mem_r[`ICR_ADDR_RT_FILT][`ICR_FILT_W-1:0];
   assign line_coef.pole_a    = coef_mem_r[`ICR_ADDR_POLE_A][`ICR_FILT_W-1:0];
   assign line_coef.pole_b    = coef_mem_r[`ICR_ADDR_POLE_B][`ICR_FILT_W-1:0];
   assign line_coef.pole_c    = coef_mem_r[`ICR_ADDR_POLE_C][`ICR_FILT_W-1:0];
   assign line_coef.ring_bias = coef_mem_r[`ICR_ADDR_RING_BIAS][`ICR_BIAS_W-1:0];
   assign line_coef.overhead  = coef_mem_r[`ICR_ADDR_OVERHEAD][`ICR_BIAS_W-1:0];

   // gain fields, signed
   assign rx_gain = coef_mem_r[`ICR_ADDR_RX_GAIN][`ICR_GAIN_W-1:0];
   assign tx_gain = coef_mem_r[`ICR_ADDR_TX_GAIN][`ICR_GAIN_W-1:0];

   // common-mode thresholds as signed limits
   assign cm_hi_s = $signed({2'b00, line_coef.cm_high});
   assign cm_lo_s = -$signed({2'b00, line_coef.cm_low});

   // ****************************************************************
   // datapath: gain, offset, detectors
   // ****************************************************************
   // next values of the scaled samples and detector flags
   always_comb begin
      rx_nxt     = rx_r;
      tx_nxt     = tx_r;
      rx_v_nxt   = rx_raw_valid;
      tx_v_nxt   = tx_raw_valid;
      ofs_hv_nxt = {2'b00, ring_coef.dc_offset} * `ICR_OFS_HV_STEP;
      lc_nxt     = lc_r;
      if (rx_raw_valid) begin
         rx_nxt = func_enable.rx_gain_en ? icr_scale(rx_raw, rx_gain) : rx_raw;
      end
      if (tx_raw_valid) begin
         tx_nxt = func_enable.tx_gain_en ? icr_scale(tx_raw, tx_gain) : tx_raw;
      end
      if (!ctrl_r.lc_hyst_en) begin
         lc_nxt = loop_current > line_coef.lc_upper;
      end else if (loop_current > line_coef.lc_upper) begin
         lc_nxt = 1'b1;
      end else if (loop_current < line_coef.lc_lower) begin
         lc_nxt = 1'b0;
      end
      cm_nxt = ($signed({cm_level[6], cm_level}) > cm_hi_s) ||
               ($signed({cm_level[6], cm_level}) < cm_lo_s);
   end

   // datapath registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_r     <= '0;
         tx_r     <= '0;
         rx_v_r   <= 1'b0;
         tx_v_r   <= 1'b0;
         ofs_hv_r <= '0;
         lc_r     <= 1'b0;
         cm_r     <= 1'b0;
      end else begin
         rx_r     <= rx_nxt;
         tx_r     <= tx_nxt;
         rx_v_r   <= rx_v_nxt;
         tx_v_r   <= tx_v_nxt;
         ofs_hv_r <= ofs_hv_nxt;
         lc_r     <= lc_nxt;
         cm_r     <= cm_nxt;
      end
   end

   assign rx_scaled            = rx_r;
   assign rx_scaled_valid      = rx_v_r;
   assign tx_scaled            = tx_r;
   assign tx_scaled_valid      = tx_v_r;
   assign ring_offset_halfvolt = ofs_hv_r;
   assign loop_closed          = lc_r;
   assign cm_speedup           = cm_r;

   // ****************************************************************
   // assertions
   // ****************************************************************
   AST_READBACK_FULL:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `ICR_ADDR_TONE1_FRQ) ##1
      (reg_rd && !reg_wr && reg_addr == `ICR_ADDR_TONE1_FRQ)
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("coefficient readback differs from written word");

   AST_TONE_TWO_FREQ:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      reg_wr && reg_addr == `ICR_ADDR_TONE2_FRQ |=> tone_two_coef.freq == $past(reg_wdata))
      else $error("tone two frequency not taken from its register");

   AST_RING_AMP:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      reg_wr && reg_addr == `ICR_ADDR_RING_AMP |=> ring_coef.amp == $past(reg_wdata))
      else $error("ringing amplitude not taken from its register");

   AST_METER_RAMP:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      reg_wr && reg_addr == `ICR_ADDR_MTR_RAMP |=> meter_coef.ramp == $past(reg_wdata))
      else $error("metering ramp not taken from its register");

   AST_ALARM_WIDTH:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      reg_wr && reg_addr == `ICR_ADDR_ALARM_A
      |=> line_coef.alarm_a == $past(reg_wdata[7:0]))
      else $error("power alarm field wrong width or value");

   AST_RING_OFFSET:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      reg_wr && reg_addr == `ICR_ADDR_RING_OFS
      |=> ##1 ring_offset_halfvolt == 8'($past(reg_wdata[5:0], 2) * 3))
      else $error("ringing offset not three half volts per code");

   AST_RX_MUTE:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      rx_raw_valid && func_enable.rx_gain_en && rx_gain == 12'h000
      |=> rx_scaled_valid && rx_scaled == '0)
      else $error("zero receive gain does not mute");

   AST_TX_UNITY:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      tx_raw_valid && func_enable.tx_gain_en && tx_gain == 12'h400
      |=> tx_scaled_valid && tx_scaled == $past(tx_raw))
      else $error("unity transmit gain alters sample");

   AST_SIGNED_GAIN:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      rx_raw_valid && func_enable.rx_gain_en && rx_gain == 12'hc00
      && rx_raw == 16'sh0100 |=> rx_scaled == 16'shff00)
      else $error("negative gain not treated as two's complement");

   AST_LOOP_CLOSE:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      loop_current > line_coef.lc_upper |=> loop_closed)
      else $error("loop closure missed above upper threshold");

   AST_LOOP_HYST:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      ctrl_r.lc_hyst_en && loop_closed && loop_current >= line_coef.lc_lower
      && loop_current <= line_coef.lc_upper |=> loop_closed)
      else $error("hysteresis released loop closure too early");

   AST_CM_SPEEDUP:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      $signed({cm_level[6], cm_level}) > cm_hi_s |=> cm_speedup)
      else $error("common-mode speed-up missed above high threshold");

   AST_GATED_ENABLE:
   assert property (@(posedge sys_clk) disable iff (!rst_b)
      func_enable.tone_one_en |-> coef_ready.tone_one)
      else $error("tone enabled before its coefficients were written");

endmodule

//--- icr_defines.svh
`ifndef ICR_DEFINES_SVH
`define ICR_DEFINES_SVH

// ****************************************************************
// bus geometry
// ****************************************************************
`define ICR_ADDR_W         6
`define ICR_DATA_W         16

// ****************************************************************
// coefficient addresses
// ****************************************************************
`define ICR_ADDR_FIRST     6'h0d
`define ICR_ADDR_TONE1_FRQ 6'h0d
`define ICR_ADDR_TONE1_AMP 6'h0e
`define ICR_ADDR_TONE1_PHS 6'h0f
`define ICR_ADDR_TONE2_FRQ 6'h10
`define ICR_ADDR_TONE2_AMP 6'h11
`define ICR_ADDR_TONE2_PHS 6'h12
`define ICR_ADDR_RING_OFS  6'h13
`define ICR_ADDR_RING_FRQ  6'h14
`define ICR_ADDR_RING_AMP  6'h15
`define ICR_ADDR_RING_PHS  6'h16
`define ICR_ADDR_MTR_RAMP  6'h17
`define ICR_ADDR_MTR_AMP   6'h18
`define ICR_ADDR_MTR_FRQ   6'h19
`define ICR_ADDR_RX_GAIN   6'h1a
`define ICR_ADDR_TX_GAIN   6'h1b
`define ICR_ADDR_LC_UPPER  6'h1c
`define ICR_ADDR_RT_THR    6'h1d
`define ICR_ADDR_CM_LOW    6'h1e
`define ICR_ADDR_CM_HIGH   6'h1f
`define ICR_ADDR_ALARM_A   6'h20
`define ICR_ADDR_ALARM_B   6'h21
`define ICR_ADDR_ALARM_C   6'h22
`define ICR_ADDR_LC_FILT   6'h23
`define ICR_ADDR_RT_FILT   6'h24
`define ICR_ADDR_POLE_A    6'h25
`define ICR_ADDR_POLE_B    6'h26
`define ICR_ADDR_POLE_C    6'h27
`define ICR_ADDR_RING_BIAS 6'h28
`define ICR_ADDR_OVERHEAD  6'h29
`define ICR_ADDR_RSVD      6'h2a
`define ICR_ADDR_LC_LOWER  6'h2b
`define ICR_ADDR_LAST      6'h2b
`define ICR_ADDR_STATUS    6'h2c
`define ICR_ADDR_CTRL      6'h2d

// ****************************************************************
// field widths, scales and reset values
// ****************************************************************
`define ICR_THR_W          6
`define ICR_ALARM_W        8
`define ICR_FILT_W         13
`define ICR_BIAS_W         4
`define ICR_GAIN_W         12
`define ICR_OFS_W          6
`define ICR_OFS_HV_W       8
`define ICR_OFS_HV_STEP    8'h03
`define ICR_GAIN_FRAC      10
`define ICR_GAIN_UNITY     12'h400
`define ICR_CTRL_RST       8'h00

`endif

//--- icr_pkg.sv
package icr_pkg;

   // tone generator coefficient set
   typedef struct packed {
      logic [15:0] freq;
      logic [15:0] amp;
      logic [15:0] phase;
   } icr_osc_t;

   // ringing generator coefficient set
   typedef struct packed {
      logic [5:0]  dc_offset;
      logic [15:0] freq;
      logic [15:0] amp;
      logic [15:0] phase;
   } icr_ring_t;

   // pulse metering coefficient set
   typedef struct packed {
      logic [15:0] ramp;
      logic [15:0] amp;
      logic [15:0] freq;
   } icr_meter_t;

   // line control fields
   typedef struct packed {
      logic [5:0]  lc_upper;
      logic [5:0]  lc_lower;
      logic [5:0]  ring_trip;
      logic [5:0]  cm_low;
      logic [5:0]  cm_high;
      logic [7:0]  alarm_a;
      logic [7:0]  alarm_b;
      logic [7:0]  alarm_c;
      logic [12:0] lc_filter;
      logic [12:0] rt_filter;
      logic [12:0] pole_a;
      logic [12:0] pole_b;
      logic [12:0] pole_c;
      logic [3:0]  ring_bias;
      logic [3:0]  overhead;
   } icr_line_t;

   // control register layout
   typedef struct packed {
      logic overhead_range_select;
      logic lc_hyst_en;
      logic tx_gain_en;
      logic rx_gain_en;
      logic meter_en;
      logic ring_en;
      logic tone_two_en;
      logic tone_one_en;
   } icr_ctrl_t;

   // coefficient groups fully written since reset
   typedef struct packed {
      logic line;
      logic tx_gain;
      logic rx_gain;
      logic meter;
      logic ring;
      logic tone_two;
      logic tone_one;
   } icr_ready_t;

endpackage

//--- tb_top.sv
`include "icr_defines.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************************************
   // signals
   // ****************************************************************
   logic                      sys_clk, rst_b, reg_wr, reg_rd, rd_d;
   logic [5:0]                reg_addr, loop_current;
   logic [15:0]               reg_wdata, reg_rdata, d, dummy;
   logic signed [15:0]        rx_raw, tx_raw, rx_scaled, tx_scaled, s, t;
   logic                      rx_raw_valid, tx_raw_valid, rx_scaled_valid, tx_scaled_valid;
   logic signed [6:0]         cm_level;
   logic                      loop_closed, cm_speedup;
   logic [7:0]                ring_offset_halfvolt;
   icr_pkg::icr_osc_t         tone_one_coef, tone_two_coef;
   icr_pkg::icr_ring_t        ring_coef;
   icr_pkg::icr_meter_t       meter_coef;
   icr_pkg::icr_line_t        line_coef;
   icr_pkg::icr_ctrl_t        func_enable;
   icr_pkg::icr_ready_t       coef_ready;
   logic [15:0]               mem [0:63];
   logic [15:0]               q_rd[$];
   logic signed [15:0]        q_rx[$], q_tx[$];
   logic [11:0]               gt [0:3];
   int                        error_cnt, num_checks, cyc, i, j;

   icr_bank dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tone_one_coef(tone_one_coef), .tone_two_coef(tone_two_coef), .ring_coef(ring_coef),
      .ring_offset_halfvolt(ring_offset_halfvolt), .meter_coef(meter_coef),
      .line_coef(line_coef), .func_enable(func_enable), .coef_ready(coef_ready),
      .rx_raw(rx_raw), .rx_raw_valid(rx_raw_valid), .rx_scaled(rx_scaled),
      .rx_scaled_valid(rx_scaled_valid), .tx_raw(tx_raw), .tx_raw_valid(tx_raw_valid),
      .tx_scaled(tx_scaled), .tx_scaled_valid(tx_scaled_valid),
      .loop_current(loop_current), .cm_level(cm_level), .loop_closed(loop_closed),
      .cm_speedup(cm_speedup));

   // ****************************************************************
   // clock, timeout and result watcher
   // ****************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      rd_d <= reg_rd;
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // oldest note against each result as it appears
   always @(negedge sys_clk) begin
      if (rd_d === 1'b1) chk("reg_rdata", reg_rdata, q_rd.pop_front());
      if (rx_scaled_valid === 1'b1) chk("rx_scaled", rx_scaled, q_rx.pop_front());
      if (tx_scaled_valid === 1'b1) chk("tx_scaled", tx_scaled, q_tx.pop_front());
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // write a word and note it as expected content
   task automatic wm(input logic [5:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      mem[a] = v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // write then read back with no gap between strobes
   task automatic wr_rd(input logic [5:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      mem[a] = v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      q_rd.push_back(v);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      q_rd.push_back(mem[a]);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic samp(input logic signed [15:0] a, b, ea, eb);
      @(posedge sys_clk);
      rx_raw <= a;
      tx_raw <= b;
      rx_raw_valid <= 1'b1;
      tx_raw_valid <= 1'b1;
      q_rx.push_back(ea);
      q_tx.push_back(eb);
      @(posedge sys_clk);
      rx_raw_valid <= 1'b0;
      tx_raw_valid <= 1'b0;
   endtask

   task automatic det(input logic [5:0] cur, input logic [6:0] cm, input logic elc, ecm);
      @(posedge sys_clk);
      loop_current <= cur;
      cm_level <= cm;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("loop_closed", loop_closed, elc);
      chk("cm_speedup", cm_speedup, ecm);
   endtask

   // signed gain, shift by ten, saturate
   function automatic logic signed [15:0] gexp(input logic signed [15:0] v,
                                               input logic signed [11:0] g);
      logic signed [31:0] p;
      p = v * g;
      p = p >>> 10;
      if (p > 32'sh7fff) return 16'sh7fff;
      if (p < -32'sh8000) return 16'sh8000;
      return p[15:0];
   endfunction

   // defined field mask of each word
   function automatic logic [15:0] fw(input logic [5:0] a);
      case (a)
         6'h13, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h2b: return 16'h003f;
         6'h1a, 6'h1b: return 16'h0fff;
         6'h20, 6'h21, 6'h22: return 16'h00ff;
         6'h23, 6'h24, 6'h25, 6'h26, 6'h27: return 16'h1fff;
         6'h28: return 16'h000f;
         6'h29: return 16'h0003; // overhead code kept low
         default: return 16'hffff;
      endcase
   endfunction

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {rst_b, reg_wr, reg_rd, rx_raw_valid, tx_raw_valid} = '0;
      {reg_addr, reg_wdata, rx_raw, tx_raw, loop_current, cm_level} = '0;
      gt = '{12'h000, 12'h400, 12'h7ff, 12'hc00};
      for (i = 0; i < 64; i++) mem[i] = 16'h0000;
      dummy = $urandom(32'hf549);
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      chk("coef_ready", coef_ready, 0);
      rd(6'h2c);
      wm(6'h2d, 16'h003f);
      repeat (2) @(negedge sys_clk);
      chk("func_enable", func_enable, 0);
      samp(16'h1234, 16'hedcb, 16'h1234, 16'hedcb);
      for (i = 13; i < 44; i++) wm(i[5:0], 16'($urandom()) & fw(i[5:0]));
      mem[6'h2a] = 16'h0000;
      wm(6'h1c, 16'h0014);
      wm(6'h2b, 16'h000a);
      wm(6'h1e, 16'h0008);
      wm(6'h1f, 16'h000a);
      mem[6'h2c] = 16'h007f;
      wr_rd(6'h0d, 16'($urandom()));
      for (i = 8; i < 47; i++) rd(i[5:0]);
      @(negedge sys_clk);
      chk("tone1", tone_one_coef, {mem[13], mem[14], mem[15]});
      chk("tone2", tone_two_coef, {mem[16], mem[17], mem[18]});
      chk("ring", ring_coef, {mem[19][5:0], mem[20], mem[21], mem[22]});
      chk("ring_ofs", ring_offset_halfvolt, 8'(mem[19][5:0] * 8'h03));
      chk("meter", meter_coef, {mem[23], mem[24], mem[25]});
      chk("thr", {line_coef.lc_upper, line_coef.lc_lower, line_coef.ring_trip,
         line_coef.cm_low, line_coef.cm_high}, {mem[28][5:0], mem[43][5:0],
         mem[29][5:0], mem[30][5:0], mem[31][5:0]});
      chk("alarm", {line_coef.alarm_a, line_coef.alarm_b, line_coef.alarm_c},
         {mem[32][7:0], mem[33][7:0], mem[34][7:0]});
      chk("filt", {line_coef.lc_filter, line_coef.rt_filter, line_coef.pole_a,
         line_coef.pole_b}, {mem[35][12:0], mem[36][12:0], mem[37][12:0],
         mem[38][12:0]});
      chk("bias", {line_coef.pole_c, line_coef.ring_bias, line_coef.overhead},
         {mem[39][12:0], mem[40][3:0], mem[41][3:0]});
      chk("ready_all", {coef_ready, func_enable}, 15'h7f3f);
      for (i = 0; i < 4; i++) begin
         wm(6'h1a, {4'h0, gt[i]});
         wm(6'h1b, {4'h0, gt[(i + 1) % 4]});
         for (j = 0; j < 6; j++) begin
            s = (j == 0) ? 16'h7fff : (j == 1) ? 16'h8000 :
                (j == 2) ? 16'h0100 : 16'($urandom());
            t = (j == 0) ? 16'h8000 : (j == 1) ? 16'h7fff : 16'($urandom());
            samp(s, t, gexp(s, gt[i]), gexp(t, gt[(i + 1) % 4]));
         end
      end
      det(6'h15, 7'h00, 1'b1, 1'b0);
      det(6'h14, 7'h00, 1'b0, 1'b0);
      det(6'h00, 7'h0b, 1'b0, 1'b1);
      det(6'h00, 7'h0a, 1'b0, 1'b0);
      det(6'h00, 7'h77, 1'b0, 1'b1);
      det(6'h00, 7'h78, 1'b0, 1'b0);
      wm(6'h2d, 16'h007f);
      det(6'h15, 7'h00, 1'b1, 1'b0);
      det(6'h0f, 7'h00, 1'b1, 1'b0);
      det(6'h09, 7'h00, 1'b0, 1'b0);
      det(6'h0f, 7'h00, 1'b0, 1'b0);
      repeat (3) @(negedge sys_clk);
      chk("queues", q_rd.size() + q_rx.size() + q_tx.size(), 0);
      tally_and_finish();
   end
endmodule
